// File: hdl/ubar_dev.sv
// Serial port with rate generation, framing check and address recognition.
//
// Register access over an 8-bit SFR read/write port is this design's own decision.
module ubar_dev import ubar_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Flags
    output logic rx_complete_flag,
    output logic tx_complete_flag,
    // Serial lines
    ubar_link_if.dev link
);
    typedef struct packed {
        logic [1:0] mode;
        logic mp;
        logic ren;
        logic tx9;
        logic rx9;
        logic txc;
        logic rxc;
        logic fe;
        logic dbl;
        logic fe_en;
        logic presc;
        logic [7:0] reload;
        logic [7:0] own;
        logic [7:0] mask;
        logic [7:0] rx_buf;
        logic [7:0] rdata;
        logic [3:0] pre_cnt;
        logic [7:0] t1_cnt;
        logic ovf_ph;
        logic [1:0] m2_cnt;
        ubar_tx_state_type tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_bits;
        logic [3:0] tx_os;
        logic txd;
        logic m0_rx;
        logic [3:0] m0_cnt;
        logic dout;
        logic doe;
        ubar_rx_state_type rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_bits;
        logic [3:0] rx_os;
        logic [2:0] sync;
        logic lvl;
    } ubar_dev_state_type;

    ubar_dev_state_type s;
    ubar_dev_state_type n;

    always_comb begin
        logic fall;
        logic t1_tick;
        logic ovf;
        logic m2_tick;
        logic os_tick;
        logic is8;
        logic [7:0] rx_data;
        logic rx_ninth;
        logic [7:0] bcast;
        logic addr_hit;
        logic rx_load;
        logic [7:0] rd;
        logic [3:0] m0_last;
        logic [3:0] m0_rise;
        fall = 1'b0;
        t1_tick = 1'b0;
        ovf = 1'b0;
        m2_tick = 1'b0;
        os_tick = 1'b0;
        is8 = 1'b0;
        rx_data = 8'h00;
        rx_ninth = 1'b0;
        bcast = 8'h00;
        addr_hit = 1'b0;
        rx_load = 1'b0;
        rd = 8'h00;
        m0_last = s.mp ? M0_FAST_LAST : M0_SLOW_LAST; // [RL2]
        m0_rise = s.mp ? M0_FAST_RISE : M0_SLOW_RISE; // [RL2]
        n = s;
        // ****************************************
        // Input filter and rate generation
        // ****************************************
        n.sync = {s.sync[1:0], link.rxd};
        if (s.sync[2] == s.sync[1]) begin
            n.lvl = s.sync[2];
        end
        fall = s.lvl && !s.sync[2] && !s.sync[1];
        t1_tick = s.pre_cnt == (s.presc ? T1_PRESC_FAST_LAST : T1_PRESC_SLOW_LAST); // [RL4]
        n.pre_cnt = t1_tick ? 4'h0 : s.pre_cnt + 4'h1;
        ovf = t1_tick && (s.t1_cnt == T1_TOP);
        if (t1_tick) begin
            n.t1_cnt = ovf ? s.reload : s.t1_cnt + 8'h01; // [RL6]
        end
        if (ovf) begin
            n.ovf_ph = ~s.ovf_ph;
        end
        m2_tick = s.m2_cnt == (s.dbl ? M2_OS_FAST_LAST : M2_OS_SLOW_LAST); // [RL3]
        n.m2_cnt = m2_tick ? 2'h0 : s.m2_cnt + 2'h1;
        os_tick = (s.mode == MODE_FIX9) ? m2_tick : (ovf && (s.dbl || s.ovf_ph)); // [RL1] [RL7]
        // ****************************************
        // Register port
        // ****************************************
        if (sfr_wr) begin
            case (sfr_addr)
                SFR_SERIAL_CTRL: begin
                    if (s.fe_en) begin
                        n.fe = sfr_wdata[BIT_MODE_HI]; // [RL9] [RL10]
                    end else begin
                        n.mode[1] = sfr_wdata[BIT_MODE_HI]; // [RL9]
                    end
                    n.mode[0] = sfr_wdata[BIT_MODE_LO];
                    n.mp = sfr_wdata[BIT_MP];
                    n.ren = sfr_wdata[BIT_REN];
                    n.tx9 = sfr_wdata[BIT_TX9];
                    n.rx9 = sfr_wdata[BIT_RX9];
                    n.txc = sfr_wdata[BIT_TXC];
                    n.rxc = sfr_wdata[BIT_RXC];
                    if (n.mode == MODE_SYNC && !s.ren && sfr_wdata[BIT_REN]
                        && !sfr_wdata[BIT_RXC] && s.tx_st == TX_IDLE) begin
                        n.tx_st = TX_SYNC;
                        n.m0_rx = 1'b1;
                        n.m0_cnt = 4'h0;
                        n.txd = 1'b0;
                        n.tx_bits = M0_BITS;
                        n.doe = 1'b0;
                    end
                end
                SFR_DATA_BUF: begin
                    if (s.tx_st == TX_IDLE && s.mode == MODE_SYNC) begin
                        n.tx_st = TX_SYNC;
                        n.m0_rx = 1'b0;
                        n.m0_cnt = 4'h0;
                        n.txd = 1'b0;
                        n.tx_bits = M0_BITS;
                        n.tx_sh = {3'h0, sfr_wdata};
                        n.dout = sfr_wdata[0];
                        n.doe = 1'b1;
                    end else if (s.tx_st == TX_IDLE) begin
                        n.tx_st = TX_ASYNC;
                        n.tx_os = 4'h0;
                        n.txd = 1'b0;
                        if (s.mode == MODE_ASYNC8) begin
                            n.tx_sh = {3'h7, sfr_wdata};
                            n.tx_bits = ASYNC8_TX_BITS;
                        end else begin
                            n.tx_sh = {2'h3, s.tx9, sfr_wdata}; // [RL22]
                            n.tx_bits = NINE_TX_BITS;
                        end
                    end
                end
                SFR_POWER_CTRL: begin
                    n.dbl = sfr_wdata[BIT_BAUD_DBL];
                    n.fe_en = sfr_wdata[BIT_FE_EN];
                end
                SFR_CLOCK_CTRL: n.presc = sfr_wdata[BIT_T1_PRESC];
                SFR_T1_RELOAD: n.reload = sfr_wdata;
                SFR_OWN_ADDR: n.own = sfr_wdata;
                SFR_ADDR_MASK: n.mask = sfr_wdata;
                default: ;
            endcase
        end
        if (sfr_rd) begin
            case (sfr_addr)
                SFR_SERIAL_CTRL: begin
                    rd[BIT_MODE_HI] = s.fe_en ? s.fe : s.mode[1]; // [RL9] [RL11]
                    rd[BIT_MODE_LO] = s.mode[0];
                    rd[BIT_MP] = s.mp;
                    rd[BIT_REN] = s.ren;
                    rd[BIT_TX9] = s.tx9;
                    rd[BIT_RX9] = s.rx9;
                    rd[BIT_TXC] = s.txc;
                    rd[BIT_RXC] = s.rxc;
                end
                SFR_DATA_BUF: rd = s.rx_buf;
                SFR_POWER_CTRL: begin
                    rd[BIT_BAUD_DBL] = s.dbl;
                    rd[BIT_FE_EN] = s.fe_en;
                end
                SFR_CLOCK_CTRL: rd[BIT_T1_PRESC] = s.presc;
                SFR_T1_RELOAD: rd = s.reload;
                SFR_OWN_ADDR: rd = s.own;
                SFR_ADDR_MASK: rd = s.mask;
                default: rd = 8'h00;
            endcase
            n.rdata = rd;
        end
        // ****************************************
        // Transmitter and synchronous shifter
        // ****************************************
        unique case (s.tx_st)
            TX_IDLE: ;
            TX_ASYNC: begin
                if (os_tick) begin
                    n.tx_os = s.tx_os + 4'h1;
                    if (s.tx_os == OS_LAST && s.tx_bits == 4'h0) begin
                        n.tx_st = TX_IDLE;
                    end else if (s.tx_os == OS_LAST) begin
                        n.txd = s.tx_sh[0];
                        n.tx_sh = {1'b1, s.tx_sh[10:1]};
                        n.tx_bits = s.tx_bits - 4'h1;
                        if (s.tx_bits == 4'h1) begin
                            n.txc = 1'b1;
                        end
                    end
                end
            end
            TX_SYNC: begin
                n.m0_cnt = s.m0_cnt + 4'h1;
                if (s.m0_cnt == m0_rise) begin
                    n.txd = 1'b1;
                    if (s.m0_rx) begin
                        n.tx_sh = {3'h0, s.lvl, s.tx_sh[7:1]};
                    end
                end
                if (s.m0_cnt == m0_last) begin
                    n.m0_cnt = 4'h0;
                    n.tx_bits = s.tx_bits - 4'h1;
                    n.txd = 1'b0;
                    if (!s.m0_rx) begin
                        n.tx_sh = {1'b0, s.tx_sh[10:1]};
                        n.dout = s.tx_sh[1];
                    end
                    if (s.tx_bits == 4'h1) begin
                        n.tx_st = TX_IDLE;
                        n.txd = 1'b1;
                        n.doe = 1'b0;
                        if (s.m0_rx) begin
                            n.rx_buf = s.tx_sh[7:0]; // [RL16]
                            n.rxc = 1'b1;
                        end else begin
                            n.txc = 1'b1;
                        end
                    end
                end
            end
            default: n.tx_st = TX_IDLE;
        endcase
        // ****************************************
        // Asynchronous receiver
        // ****************************************
        is8 = s.mode == MODE_ASYNC8;
        rx_data = is8 ? s.rx_sh[8:1] : s.rx_sh[7:0]; // [RL22]
        rx_ninth = is8 ? s.lvl : s.rx_sh[8]; // [RL12] [RL18]
        bcast = s.own | s.mask; // [RL20]
        addr_hit = (((rx_data ^ s.own) & s.mask) == 8'h00) // [RL19] [RL21]
            || (((rx_data ^ bcast) & bcast) == 8'h00); // [RL20]
        rx_load = !s.rxc && (!s.mp || (rx_ninth && addr_hit)); // [RL13] [RL16] [RL17]
        unique case (s.rx_st)
            RX_IDLE: begin
                if (s.ren && s.mode != MODE_SYNC && fall) begin
                    n.rx_st = RX_START;
                    n.rx_os = 4'h0;
                end
            end
            RX_START: begin
                if (os_tick) begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == OS_MID) begin
                        n.rx_os = 4'h0;
                        n.rx_bits = 4'h0;
                        n.rx_st = s.lvl ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA: begin
                if (os_tick) begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == OS_LAST) begin
                        n.rx_sh = {s.lvl, s.rx_sh[8:1]};
                        n.rx_bits = s.rx_bits + 4'h1;
                        if (s.rx_bits == (is8 ? ASYNC8_RX_LAST : NINE_RX_LAST)) begin
                            n.rx_st = RX_IDLE;
                            if (!s.lvl) begin
                                n.fe = 1'b1; // [RL8] [RL10]
                            end
                            if (rx_load) begin
                                n.rx_buf = rx_data;
                                n.rx9 = rx_ninth; // [RL12] [RL18]
                                n.rxc = 1'b1; // [RL13] [RL17] [RL18]
                            end
                        end
                    end
                end
            end
            default: n.rx_st = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.txd <= 1'b1;
            s.lvl <= 1'b1;
            s.sync <= SYNC_IDLE;
        end else begin
            s <= n;
        end
    end

    assign sfr_rdata = s.rdata;
    assign rx_complete_flag = s.rxc;
    assign tx_complete_flag = s.txc;
    assign link.txd = s.txd;
    assign link.rxd_dev_o = s.dout;
    assign link.rxd_dev_oe = s.doe;
endmodule // ubar_dev

// File: hdl/ubar_pkg.sv
// Constants and types shared by both ends of the serial link.
// How it works
// [RL1] Mode 3 equals Mode 2, timer-overflow clocked.
// [RL2] Mode 0 shifts at clock/12, or /4.
// [RL3] Mode 2 rate is clock/64, or /32 doubled.
// [RL4] Modes 1,3 rate follows timer reload formula.
// [RL5] Software disables timer interrupt; any timer mode.
// [RL6] Timer reload value comes from high byte.
// [RL7] Doubling bit doubles the timer-derived rate.
// [RL8] Framing error flagged only in asynchronous modes.
// [RL9] Error flag and mode bit share bit 7.
// [RL10] Error flag sticky until software clears it.
// [RL11] Software sets detect enable to reach error flag.
// [RL12] Modes 2,3 store the received ninth bit.
// [RL13] Multiprocessor mode drops frames with ninth bit zero.
// [RL14] Master sends address ninth one, data zero.
// [RL15] Slave software toggles multiprocessor bit around data.
// [RL16] Mode 0 unfiltered; Mode 1 needs valid stop.
// [RL17] Multiprocessor bit enables hardware address recognition.
// [RL18] Mode 1 uses stop bit as ninth.
// [RL19] Given address is own address AND mask.
// [RL20] Broadcast address is own address OR mask.
// [RL21] Reset clears both address bytes, matching everything.
// [RL22] Modes 2,3 frame: start, eight data, ninth, stop.
package ubar_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] SFR_SERIAL_CTRL = 8'h98;
    localparam logic [7:0] SFR_DATA_BUF = 8'h99;
    localparam logic [7:0] SFR_POWER_CTRL = 8'h87;
    localparam logic [7:0] SFR_CLOCK_CTRL = 8'h8e;
    localparam logic [7:0] SFR_T1_RELOAD = 8'h8d;
    localparam logic [7:0] SFR_OWN_ADDR = 8'ha9;
    localparam logic [7:0] SFR_ADDR_MASK = 8'hb9;
    localparam logic [3:0] NODE_REG_CTRL = 4'h0;
    localparam logic [3:0] NODE_REG_TX = 4'h4;
    localparam logic [3:0] NODE_REG_RX = 4'h8;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_MP = 5;
    localparam int BIT_REN = 4;
    localparam int BIT_TX9 = 3;
    localparam int BIT_RX9 = 2;
    localparam int BIT_TXC = 1;
    localparam int BIT_RXC = 0;
    localparam int BIT_BAUD_DBL = 7;
    localparam int BIT_FE_EN = 6;
    localparam int BIT_T1_PRESC = 4;
    // ****************************************
    // Modes, counts and reset values
    // ****************************************
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_ASYNC8 = 2'h1;
    localparam logic [1:0] MODE_FIX9 = 2'h2;
    localparam logic [3:0] T1_PRESC_SLOW_LAST = 4'hb;
    localparam logic [3:0] T1_PRESC_FAST_LAST = 4'h3;
    localparam logic [3:0] M0_SLOW_LAST = 4'hb;
    localparam logic [3:0] M0_FAST_LAST = 4'h3;
    localparam logic [3:0] M0_SLOW_RISE = 4'h6;
    localparam logic [3:0] M0_FAST_RISE = 4'h2;
    localparam logic [1:0] M2_OS_SLOW_LAST = 2'h3;
    localparam logic [1:0] M2_OS_FAST_LAST = 2'h1;
    localparam logic [7:0] T1_TOP = 8'hff;
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] M0_BITS = 4'h8;
    localparam logic [3:0] ASYNC8_TX_BITS = 4'h9;
    localparam logic [3:0] NINE_TX_BITS = 4'ha;
    localparam logic [3:0] ASYNC8_RX_LAST = 4'h8;
    localparam logic [3:0] NINE_RX_LAST = 4'h9;
    localparam logic [2:0] SYNC_IDLE = 3'h7;
    localparam logic [15:0] NODE_BITCLK_RESET = 16'h0040;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} ubar_tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ubar_rx_state_type;
endpackage

// File: hdl/ubar_link_if.sv
// Serial lines between the controller and a remote node.
interface ubar_link_if;
    logic txd;
    logic rxd_dev_o;
    logic rxd_dev_oe;
    logic rxd_node_o;
    logic rxd;
    assign rxd = rxd_dev_oe ? rxd_dev_o : rxd_node_o;
    modport dev (output txd, output rxd_dev_o, output rxd_dev_oe, input rxd);
    modport node (input txd, output rxd_node_o);
endinterface

// File: hdl/ubar_node.sv
// Remote serial node driven by software over AXI4-Lite.
module ubar_node import ubar_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // AXI4-Lite slave
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial lines
    ubar_link_if.node link
);
    typedef struct packed {
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [16:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] bit_clocks;
        logic nine_en;
        logic tx_busy;
        logic [9:0] tx_sh;
        logic [3:0] tx_bits;
        logic [15:0] tx_cnt;
        logic txd;
        ubar_rx_state_type rx_st;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bits;
        logic [8:0] rx_sh;
        logic [2:0] sync;
        logic lvl;
        logic [8:0] rx_data;
        logic rx_valid;
        logic rx_ferr;
    } ubar_node_state_type;

    ubar_node_state_type s;
    ubar_node_state_type n;

    always_comb begin
        logic fall;
        logic bit_end;
        fall = 1'b0;
        bit_end = 1'b0;
        n = s;
        n.sync = {s.sync[1:0], link.txd};
        if (s.sync[2] == s.sync[1]) begin
            n.lvl = s.sync[2];
        end
        fall = s.lvl && !s.sync[2] && !s.sync[1];
        // ****************************************
        // Bus slave
        // ****************************************
        if (awvalid && !s.aw_got) begin
            n.aw_got = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && !s.w_got) begin
            n.w_got = 1'b1;
            n.w_data = wdata[16:0];
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (s.aw_addr)
                NODE_REG_CTRL: begin
                    n.bit_clocks = s.w_data[15:0];
                    n.nine_en = s.w_data[16];
                end
                NODE_REG_TX: begin
                    if (!s.tx_busy) begin
                        n.tx_busy = 1'b1;
                        n.txd = 1'b0;
                        n.tx_cnt = 16'h0000;
                        n.tx_sh = s.nine_en ? {1'b1, s.w_data[8:0]} // [RL14] [RL22]
                            : {2'h3, s.w_data[7:0]};
                        n.tx_bits = s.nine_en ? NINE_TX_BITS : ASYNC8_TX_BITS;
                    end
                end
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && !s.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            case (araddr)
                NODE_REG_CTRL: n.rdata = {15'h0000, s.nine_en, s.bit_clocks};
                NODE_REG_TX: n.rdata = {31'h00000000, s.tx_busy};
                NODE_REG_RX: begin
                    n.rdata = {21'h000000, s.rx_ferr, s.rx_valid, s.rx_data};
                    n.rx_valid = 1'b0;
                end
                default: begin
                    n.rdata = 32'h00000000;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        // ****************************************
        // Transmitter
        // ****************************************
        bit_end = s.tx_cnt == s.bit_clocks - 16'h0001;
        if (s.tx_busy) begin
            n.tx_cnt = bit_end ? 16'h0000 : s.tx_cnt + 16'h0001;
            if (bit_end && s.tx_bits == 4'h0) begin
                n.tx_busy = 1'b0;
            end else if (bit_end) begin
                n.txd = s.tx_sh[0];
                n.tx_sh = {1'b1, s.tx_sh[9:1]};
                n.tx_bits = s.tx_bits - 4'h1;
            end
        end
        // ****************************************
        // Receiver
        // ****************************************
        n.rx_cnt = s.rx_cnt + 16'h0001;
        unique case (s.rx_st)
            RX_IDLE: begin
                if (fall) begin
                    n.rx_st = RX_START;
                    n.rx_cnt = 16'h0000;
                end
            end
            RX_START: begin
                if (s.rx_cnt == {1'b0, s.bit_clocks[15:1]}) begin
                    n.rx_cnt = 16'h0000;
                    n.rx_bits = 4'h0;
                    n.rx_st = s.lvl ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (s.rx_cnt == s.bit_clocks - 16'h0001) begin
                    n.rx_cnt = 16'h0000;
                    n.rx_sh = {s.lvl, s.rx_sh[8:1]};
                    n.rx_bits = s.rx_bits + 4'h1;
                    if (s.rx_bits == (s.nine_en ? NINE_RX_LAST : ASYNC8_RX_LAST)) begin
                        n.rx_st = RX_IDLE;
                        n.rx_data = s.nine_en ? s.rx_sh : {s.lvl, s.rx_sh[8:1]};
                        n.rx_ferr = !s.lvl;
                        n.rx_valid = 1'b1;
                    end
                end
            end
            default: n.rx_st = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.bit_clocks <= NODE_BITCLK_RESET;
            s.txd <= 1'b1;
            s.lvl <= 1'b1;
            s.sync <= SYNC_IDLE;
        end else begin
            s <= n;
        end
    end

    assign awready = !s.aw_got;
    assign wready = !s.w_got;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign link.rxd_node_o = s.txd;
endmodule // ubar_node

// File: testbench/ubar_link_props.sv
// Checker watching the serial lines between the two ends.
module ubar_link_props (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial lines
    input wire logic txd,
    input wire logic rxd_dev_o,
    input wire logic rxd_dev_oe,
    input wire logic rxd_node_o,
    input wire logic rxd
);
    // ****************************************
    // Line checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_line_resolve: assert property (rxd == (rxd_dev_oe ? rxd_dev_o : rxd_node_o))
        else $error("rxd level wrong");
    a_reset_idle: assert property (disable iff (1'b0) $fell(srst) |-> txd && !rxd_dev_oe)
        else $error("line not idle after reset");
    a_sync_start: assert property ($rose(rxd_dev_oe) |-> !txd)
        else $error("shift clock not low at start");
    a_sync_low: assert property (rxd_dev_oe && $fell(txd) |-> !txd [*2])
        else $error("shift clock low too short");
    a_sync_end: assert property ($fell(rxd_dev_oe) |-> txd)
        else $error("shift clock not high at end");
    a_sync_data: assert property (rxd_dev_oe && $past(rxd_dev_oe) && !$fell(txd) |-> $stable(rxd_dev_o))
        else $error("shift data moved off clock fall");
    a_async_bit: assert property (!rxd_dev_oe && !$past(rxd_dev_oe) && $changed(txd) |=> $stable(txd) [*8])
        else $error("async bit too short");
    a_node_bit: assert property ($changed(rxd_node_o) |=> $stable(rxd_node_o) [*3])
        else $error("node bit too short");
    cover property ($rose(rxd_dev_oe));
    cover property ($fell(rxd_node_o));
    cover property (!rxd_dev_oe && $fell(txd));
endmodule // ubar_link_props

// File: testbench/ubar_tb.sv
// Bench joining controller and remote node over the serial link.
module ubar_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, rx_complete_flag, tx_complete_flag;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [9:0] mp_frames [4] = '{10'h1c1, 10'h0c2, 10'h3c2, 10'h3ff};
    int fail_count = 0, checks_done = 0, cyc = 0;
    // ****************************************
    // Instances and tasks
    // ****************************************
    always #20 clk = ~clk;
    ubar_link_if ubar_link_if_i ();
    ubar_dev ubar_dev_i (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .rx_complete_flag, .tx_complete_flag, .link(ubar_link_if_i.dev));
    ubar_node ubar_node_i (.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .link(ubar_link_if_i.node));
    ubar_link_props ubar_link_props_i (.clk, .srst, .txd(ubar_link_if_i.txd),
        .rxd_dev_o(ubar_link_if_i.rxd_dev_o), .rxd_dev_oe(ubar_link_if_i.rxd_dev_oe),
        .rxd_node_o(ubar_link_if_i.rxd_node_o), .rxd(ubar_link_if_i.rxd));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic sw(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sr(input logic [7:0] a, input logic [7:0] e);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
        chk(sfr_rdata, e);
    endtask
    task automatic aw(input logic [3:0] a, input logic [31:0] d);
        logic ao, wo, bo;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk) {ao, wo, bo} = {awready, wready, bvalid};
            @(posedge clk);
            if (ao) awvalid <= 1'b0;
            if (wo) wvalid <= 1'b0;
        end while (!bo);
        bready <= 1'b0;
        chk(bresp, 2'h0);
    endtask
    task automatic ar(input logic [3:0] a, input logic [31:0] e);
        logic ao, ro;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk) {ao, ro} = {arready, rvalid};
            @(posedge clk);
            if (ao) arvalid <= 1'b0;
        end while (!ro);
        rready <= 1'b0;
        chk(rdata, e);
    endtask
    task automatic tx(input logic [8:0] v);
        aw(4'h4, {23'h0, v});
        repeat (800) @(posedge clk);
    endtask
    task close_out;
        $display("fail_count %0d checks_done %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        sr(8'ha9, 8'h00);
        sr(8'hb9, 8'h00);
        sr(8'h00, 8'h00);
        aw(4'h0, 32'h10040);
        sw(8'h98, 8'h98);
        tx(9'h15a);
        sr(8'h99, 8'h5a);
        sr(8'h98, 8'h9d);
        sw(8'h99, 8'ha5);
        repeat (800) @(posedge clk);
        ar(4'h8, 32'h3a5);
        sw(8'ha9, 8'hc0);
        sw(8'hb9, 8'hfd);
        foreach (mp_frames[i]) begin
            sw(8'h98, 8'hb0);
            tx(mp_frames[i][8:0]);
            chk(rx_complete_flag, mp_frames[i][9]);
        end
        sw(8'h8e, 8'h10);
        sw(8'h8d, 8'hff);
        sw(8'h87, 8'h80);
        sw(8'h98, 8'hd0);
        repeat (1100) @(posedge clk);
        tx(9'h13c);
        sr(8'h99, 8'h3c);
        sw(8'h98, 8'h50);
        tx(9'h000);
        sr(8'h98, 8'h51);
        sw(8'h87, 8'hc0);
        sr(8'h98, 8'hd1);
        sw(8'h98, 8'h50);
        sr(8'h98, 8'h50);
        sw(8'h98, 8'h00);
        sw(8'h99, 8'h3c);
        repeat (200) @(posedge clk);
        chk(tx_complete_flag, 1'b1);
        close_out();
    end
endmodule // ubar_tb
